// *** hdl/iafp_pkg.sv ***
// Shared constants for the in-application flash programmer and its controller
`default_nettype none
package iafp_pkg;
  // Control registers, reached with sector select one
  localparam logic [7:0] OFS_MAIN_CTRL = 8'h43;
  localparam logic [7:0] OFS_CHIP_RST  = 8'h44;
  localparam logic [7:0] OFS_BUF_CLR   = 8'h45;
  // Address and data registers, reached with sector select zero
  localparam logic [7:0] OFS_ADDR_LO   = 8'h43;
  localparam logic [7:0] OFS_ADDR_HI   = 8'h44;
  localparam logic [7:0] OFS_DATA_BASE = 8'h45;
  localparam int         DATA_REGS     = 8;
  localparam logic       SECTOR_CTRL   = 1'b1;

  // Main control and buffer clear register fields
  localparam int BIT_UNLOCKED = 7;
  localparam int OP_HI        = 6;
  localparam int OP_LO        = 4;
  localparam int BIT_ARM      = 3;
  localparam int BIT_PROG     = 2;
  localparam int BIT_RPERMIT  = 1;
  localparam int BIT_RSTART   = 0;
  localparam int BIT_BUFCLR   = 0;

  localparam logic [2:0] OP_WRITE  = 3'h0;
  localparam logic [2:0] OP_ERASE  = 3'h1;
  localparam logic [2:0] OP_READ   = 3'h3;
  localparam logic [2:0] OP_UNLOCK = 3'h6;

  localparam logic [7:0] CHIP_RESET_KEY = 8'h55;
  localparam int         PAT_LEN        = 6;
  localparam logic [7:0] UNLOCK_PAT [PAT_LEN] =
    '{8'h00, 8'h04, 8'h0d, 8'h09, 8'hc3, 8'h40};
  localparam logic [2:0] PAT_FIRST_IDX = 3'h2;

  // Unlock time-out, counted in slow oscillator ticks
  localparam int CLK_PERIOD_NS      = 50;
  localparam int SLOW_INTERNAL_OSCILLATOR_PERIOD_NS     = 31250;
  localparam int SLOW_INTERNAL_OSCILLATOR_DIV_CYCLES    = SLOW_INTERNAL_OSCILLATOR_PERIOD_NS / CLK_PERIOD_NS;
  localparam int UNLOCK_TIMEOUT_NS  = 300000;
  localparam int UNLOCK_TICKS       = UNLOCK_TIMEOUT_NS / SLOW_INTERNAL_OSCILLATOR_PERIOD_NS;

  // Flash macro operations
  localparam logic [1:0] FL_WRITE = 2'h0;
  localparam logic [1:0] FL_ERASE = 2'h1;
  localparam logic [1:0] FL_READ  = 2'h2;

  // Controller register map on AXI4-Lite
  localparam logic [3:0] HOST_CMD  = 4'h0;
  localparam logic [3:0] HOST_STAT = 4'h4;
  localparam int CMD_ADDR_LSB   = 8;
  localparam int CMD_SECTOR_BIT = 16;
  localparam int CMD_READ_BIT   = 17;
  localparam int STAT_BUSY_BIT  = 8;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;
endpackage
`default_nettype wire

// *** hdl/iafp_mem_if.sv ***
// Data memory bus between the processor side and the flash programmer
`default_nettype none
interface iafp_mem_if;
  logic       sector;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic       wr;
  logic       rd;
  logic [7:0] rdata;

  modport dev  (input sector, addr, wdata, wr, rd, output rdata);
  modport host (output sector, addr, wdata, wr, rd, input rdata);
endinterface
`default_nettype wire

// *** hdl/iafp_write_buffer.sv ***
// Word buffer that collects a write burst before programming
`default_nettype none
module iafp_write_buffer #(
  parameter int DEPTH = 128,
  parameter int CNT_W = $clog2(DEPTH) + 1
)(
  input  wire logic             sys_clk,
  input  wire logic             rst_n,
  input  wire logic             clear,
  input  wire logic             load,
  input  wire logic [15:0]      load_data,
  input  wire logic [CNT_W-1:0] rd_index,
  output logic      [15:0]      rd_data,
  output logic      [CNT_W-1:0] count
);
  logic [15:0]      mem_reg [DEPTH];
  logic [CNT_W-1:0] count_reg;
  logic [CNT_W-1:0] count_next;

  always_comb begin
    count_next = count_reg;
    if (clear) begin
      count_next = '0;
    end else if (load && count_reg < CNT_W'(DEPTH)) begin
      count_next = count_reg + 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      count_reg <= '0;
    end else begin
      count_reg <= count_next;
    end
  end

  // Words past the burst size are dropped
  always_ff @(posedge sys_clk) begin
    if (!clear && load && count_reg < CNT_W'(DEPTH)) begin
      mem_reg[count_reg[CNT_W-2:0]] <= load_data;
    end
  end

  assign rd_data = (rd_index < CNT_W'(DEPTH)) ?
                   mem_reg[rd_index[CNT_W-2:0]] : 16'h0000;
  assign count   = count_reg;
endmodule
`default_nettype wire

// *** hdl/iafp_device.sv ***
// Flash programmer: register bank, unlock sequence and flash sequencer
`default_nettype none
module iafp_device #(
  parameter int ADDR_W     = 16,
  parameter int PAGE_WORDS = 128,
  parameter int SLOW_INTERNAL_OSCILLATOR_DIV   = iafp_pkg::SLOW_INTERNAL_OSCILLATOR_DIV_CYCLES
)(
  input  wire logic              sys_clk,
  input  wire logic              rst_n,
  iafp_mem_if.dev                mem,
  output logic                   flash_req,
  output logic [1:0]             flash_op,
  output logic [ADDR_W-1:0]      flash_addr,
  output logic [15:0]            flash_wdata,
  input  wire logic              flash_ack,
  input  wire logic [15:0]       flash_rdata,
  output logic                   chip_reset
);
  localparam int PG_W  = $clog2(PAGE_WORDS);
  localparam int CNT_W = PG_W + 1;
  localparam int DIV_W = $clog2(SLOW_INTERNAL_OSCILLATOR_DIV + 1);

  typedef enum logic [2:0] {
    ST_IDLE, ST_UNLOCK, ST_PROG, ST_ERASE, ST_READ
  } iafp_dev_state_e;

  iafp_dev_state_e   state_reg, state_next;
  logic              unlocked_reg, unlocked_next;
  logic [2:0]        op_reg, op_next;
  logic              arm_reg, arm_next;
  logic              prog_reg, prog_next;
  logic              rpermit_reg, rpermit_next;
  logic              rstart_reg, rstart_next;
  logic [7:0]        rst_pat_reg, rst_pat_next;
  logic              bufclr_reg, bufclr_next;
  logic [ADDR_W-1:0] addr_reg, addr_next;
  logic [7:0]        data_reg [iafp_pkg::DATA_REGS];
  logic [7:0]        data_next [iafp_pkg::DATA_REGS];
  logic [2:0]        pat_idx_reg, pat_idx_next;
  logic [DIV_W-1:0]  div_reg, div_next;
  logic [3:0]        ticks_reg, ticks_next;
  logic [CNT_W-1:0]  wr_idx_reg, wr_idx_next;
  logic [ADDR_W-1:0] page_base_reg, page_base_next;
  logic              req_reg, req_next;
  logic [1:0]        fop_reg, fop_next;
  logic [ADDR_W-1:0] faddr_reg, faddr_next;
  logic [15:0]       fwdata_reg, fwdata_next;
  logic              chip_rst_reg, chip_rst_next;
  logic [7:0]        rdata_reg, rdata_next;

  logic              buf_clear;
  logic              buf_load;
  logic [15:0]       buf_rd;
  logic [CNT_W-1:0]  buf_count;
  logic              data_hit;
  logic [2:0]        data_idx;
  logic [15:0]       addr_full;

  assign data_hit = !mem.sector && mem.addr >= iafp_pkg::OFS_DATA_BASE &&
    mem.addr < iafp_pkg::OFS_DATA_BASE + 8'(iafp_pkg::DATA_REGS);
  assign data_idx = 3'(mem.addr - iafp_pkg::OFS_DATA_BASE);
  assign addr_full = 16'(addr_reg);

  iafp_write_buffer #(
    .DEPTH (PAGE_WORDS),
    .CNT_W (CNT_W)
  ) u_buf (
    .sys_clk   (sys_clk),
    .rst_n     (rst_n),
    .clear     (buf_clear),
    .load      (buf_load),
    .load_data ({mem.wdata, data_reg[0]}),
    .rd_index  (wr_idx_reg),
    .rd_data   (buf_rd),
    .count     (buf_count)
  );

  always_comb begin
    state_next     = state_reg;
    unlocked_next  = unlocked_reg;
    op_next        = op_reg;
    arm_next       = arm_reg;
    prog_next      = prog_reg;
    rpermit_next   = rpermit_reg;
    rstart_next    = rstart_reg;
    rst_pat_next   = rst_pat_reg;
    bufclr_next    = bufclr_reg;
    addr_next      = addr_reg;
    data_next      = data_reg;
    pat_idx_next   = pat_idx_reg;
    div_next       = div_reg;
    ticks_next     = ticks_reg;
    wr_idx_next    = wr_idx_reg;
    page_base_next = page_base_reg;
    req_next       = req_reg;
    fop_next       = fop_reg;
    faddr_next     = faddr_reg;
    fwdata_next    = fwdata_reg;
    chip_rst_next  = 1'b0;
    rdata_next     = rdata_reg;
    buf_clear      = 1'b0;
    buf_load       = 1'b0;

    // Sequencer: hardware clears come before software writes below
    case (state_reg)
      ST_IDLE: begin
        if (bufclr_reg) begin
          buf_clear   = 1'b1;
          bufclr_next = 1'b0;
        end else if (arm_reg && op_reg == iafp_pkg::OP_UNLOCK) begin
          state_next   = ST_UNLOCK;
          pat_idx_next = '0;
          div_next     = '0;
          ticks_next   = '0;
        end else if (prog_reg) begin
          if (unlocked_reg && op_reg == iafp_pkg::OP_WRITE) begin
            state_next  = ST_PROG;
            wr_idx_next = '0;
          end else if (unlocked_reg && op_reg == iafp_pkg::OP_ERASE) begin
            state_next = ST_ERASE;
            req_next   = 1'b1;
            fop_next   = iafp_pkg::FL_ERASE;
            faddr_next = {addr_reg[ADDR_W-1:PG_W], PG_W'(0)};
          end else begin
            prog_next = 1'b0;
          end
        end else if (rstart_reg) begin
          if (rpermit_reg && op_reg == iafp_pkg::OP_READ) begin
            state_next = ST_READ;
            req_next   = 1'b1;
            fop_next   = iafp_pkg::FL_READ;
            faddr_next = addr_reg;
          end else begin
            rstart_next = 1'b0;
          end
        end
      end
      ST_UNLOCK: begin
        if (div_reg == DIV_W'(SLOW_INTERNAL_OSCILLATOR_DIV - 1)) begin
          div_next   = '0;
          ticks_next = ticks_reg + 4'h1;
        end else begin
          div_next = div_reg + 1'b1;
        end
        if (!arm_reg || ticks_reg == 4'(iafp_pkg::UNLOCK_TICKS)) begin
          arm_next   = 1'b0;
          state_next = ST_IDLE;
        end
      end
      ST_PROG: begin
        if (req_reg) begin
          if (flash_ack) begin
            req_next    = 1'b0;
            wr_idx_next = wr_idx_reg + 1'b1;
          end
        end else if (wr_idx_reg == buf_count) begin
          prog_next  = 1'b0;
          state_next = ST_IDLE;
        end else begin
          req_next    = 1'b1;
          fop_next    = iafp_pkg::FL_WRITE;
          faddr_next  = page_base_reg + ADDR_W'(wr_idx_reg);
          fwdata_next = buf_rd;
        end
      end
      ST_ERASE: begin
        if (flash_ack) begin
          req_next   = 1'b0;
          prog_next  = 1'b0;
          state_next = ST_IDLE;
        end
      end
      ST_READ: begin
        if (flash_ack) begin
          req_next     = 1'b0;
          data_next[0] = flash_rdata[7:0];
          data_next[1] = flash_rdata[15:8];
          rstart_next  = 1'b0;
          state_next   = ST_IDLE;
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase

    if (mem.wr && mem.sector == iafp_pkg::SECTOR_CTRL) begin
      case (mem.addr)
        iafp_pkg::OFS_MAIN_CTRL: begin
          unlocked_next = unlocked_reg &
                          mem.wdata[iafp_pkg::BIT_UNLOCKED];
          op_next      = mem.wdata[iafp_pkg::OP_HI:iafp_pkg::OP_LO];
          arm_next     = mem.wdata[iafp_pkg::BIT_ARM];
          prog_next    = mem.wdata[iafp_pkg::BIT_PROG] | prog_next;
          rpermit_next = mem.wdata[iafp_pkg::BIT_RPERMIT];
          rstart_next  = mem.wdata[iafp_pkg::BIT_RSTART] | rstart_next;
        end
        iafp_pkg::OFS_CHIP_RST: begin
          rst_pat_next  = mem.wdata;
          chip_rst_next = mem.wdata == iafp_pkg::CHIP_RESET_KEY;
        end
        iafp_pkg::OFS_BUF_CLR: begin
          bufclr_next = mem.wdata[iafp_pkg::BIT_BUFCLR] | bufclr_next;
        end
        default: begin
        end
      endcase
    end else if (mem.wr && mem.addr == iafp_pkg::OFS_ADDR_LO) begin
      addr_next[7:0] = mem.wdata;
    end else if (mem.wr && mem.addr == iafp_pkg::OFS_ADDR_HI) begin
      addr_next = ADDR_W'({mem.wdata, addr_reg[7:0]});
    end else if (mem.wr && data_hit) begin
      data_next[data_idx] = mem.wdata;
      if (data_idx == 3'h1) begin
        buf_load  = 1'b1;
        addr_next = addr_reg + 1'b1;
        if (buf_count == '0) begin
          page_base_next = addr_reg;
        end
      end
      if (state_reg == ST_UNLOCK) begin
        if (data_idx == pat_idx_reg + iafp_pkg::PAT_FIRST_IDX &&
            mem.wdata == iafp_pkg::UNLOCK_PAT[pat_idx_reg]) begin
          if (pat_idx_reg == 3'(iafp_pkg::PAT_LEN - 1)) begin
            unlocked_next = 1'b1;
            arm_next      = 1'b0;
            state_next    = ST_IDLE;
          end else begin
            pat_idx_next = pat_idx_reg + 3'h1;
          end
        end else begin
          arm_next   = 1'b0;
          state_next = ST_IDLE;
        end
      end
    end

    if (mem.rd) begin
      rdata_next = 8'h00;
      if (mem.sector == iafp_pkg::SECTOR_CTRL) begin
        case (mem.addr)
          iafp_pkg::OFS_MAIN_CTRL: rdata_next = {unlocked_reg, op_reg,
            arm_reg, prog_reg, rpermit_reg, rstart_reg};
          iafp_pkg::OFS_CHIP_RST:  rdata_next = rst_pat_reg;
          iafp_pkg::OFS_BUF_CLR:   rdata_next = {7'h00, bufclr_reg};
          default:                 rdata_next = 8'h00;
        endcase
      end else if (mem.addr == iafp_pkg::OFS_ADDR_LO) begin
        rdata_next = addr_reg[7:0];
      end else if (mem.addr == iafp_pkg::OFS_ADDR_HI) begin
        rdata_next = addr_full[15:8];
      end else if (data_hit) begin
        rdata_next = data_reg[data_idx];
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      state_reg     <= ST_IDLE;
      unlocked_reg  <= 1'b0;
      op_reg        <= iafp_pkg::OP_WRITE;
      arm_reg       <= 1'b0;
      prog_reg      <= 1'b0;
      rpermit_reg   <= 1'b0;
      rstart_reg    <= 1'b0;
      rst_pat_reg   <= 8'h00;
      bufclr_reg    <= 1'b0;
      addr_reg      <= '0;
      data_reg      <= '{default: 8'h00};
      pat_idx_reg   <= '0;
      div_reg       <= '0;
      ticks_reg     <= 4'h0;
      wr_idx_reg    <= '0;
      page_base_reg <= '0;
      req_reg       <= 1'b0;
      fop_reg       <= iafp_pkg::FL_WRITE;
      faddr_reg     <= '0;
      fwdata_reg    <= 16'h0000;
      chip_rst_reg  <= 1'b0;
      rdata_reg     <= 8'h00;
    end else begin
      state_reg     <= state_next;
      unlocked_reg  <= unlocked_next;
      op_reg        <= op_next;
      arm_reg       <= arm_next;
      prog_reg      <= prog_next;
      rpermit_reg   <= rpermit_next;
      rstart_reg    <= rstart_next;
      rst_pat_reg   <= rst_pat_next;
      bufclr_reg    <= bufclr_next;
      addr_reg      <= addr_next;
      data_reg      <= data_next;
      pat_idx_reg   <= pat_idx_next;
      div_reg       <= div_next;
      ticks_reg     <= ticks_next;
      wr_idx_reg    <= wr_idx_next;
      page_base_reg <= page_base_next;
      req_reg       <= req_next;
      fop_reg       <= fop_next;
      faddr_reg     <= faddr_next;
      fwdata_reg    <= fwdata_next;
      chip_rst_reg  <= chip_rst_next;
      rdata_reg     <= rdata_next;
    end
  end

  assign mem.rdata   = rdata_reg;
  assign flash_req   = req_reg;
  assign flash_op    = fop_reg;
  assign flash_addr  = faddr_reg;
  assign flash_wdata = fwdata_reg;
  assign chip_reset  = chip_rst_reg;
endmodule
`default_nettype wire

// *** hdl/iafp_host.sv ***
// Processor-side controller: AXI4-Lite orders become data memory accesses
`default_nettype none
module iafp_host (
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic [3:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [3:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  iafp_mem_if.host         mem
);
  logic        aw_got_reg, aw_got_next;
  logic        w_got_reg, w_got_next;
  logic [3:0]  awaddr_reg, awaddr_next;
  logic [31:0] wdata_reg, wdata_next;
  logic        bvalid_reg, bvalid_next;
  logic [1:0]  bresp_reg, bresp_next;
  logic        rvalid_reg, rvalid_next;
  logic [1:0]  rresp_reg, rresp_next;
  logic [31:0] rdata_reg, rdata_next;
  logic [17:0] cmd_reg, cmd_next;
  logic        sector_reg, sector_next;
  logic [7:0]  maddr_reg, maddr_next;
  logic [7:0]  mwdata_reg, mwdata_next;
  logic        mwr_reg, mwr_next;
  logic        mrd_reg, mrd_next;
  logic        cap_reg, cap_next;
  logic [7:0]  rcap_reg, rcap_next;
  logic        busy;

  assign busy          = mwr_reg | mrd_reg | cap_reg;
  assign s_axi_awready = !aw_got_reg && !bvalid_reg;
  assign s_axi_wready  = !w_got_reg && !bvalid_reg;
  assign s_axi_arready = !rvalid_reg;

  always_comb begin
    aw_got_next = aw_got_reg;
    w_got_next  = w_got_reg;
    awaddr_next = awaddr_reg;
    wdata_next  = wdata_reg;
    bvalid_next = bvalid_reg;
    bresp_next  = bresp_reg;
    rvalid_next = rvalid_reg;
    rresp_next  = rresp_reg;
    rdata_next  = rdata_reg;
    cmd_next    = cmd_reg;
    sector_next = sector_reg;
    maddr_next  = maddr_reg;
    mwdata_next = mwdata_reg;
    mwr_next    = 1'b0;
    mrd_next    = 1'b0;
    cap_next    = mrd_reg;
    rcap_next   = cap_reg ? mem.rdata : rcap_reg;

    if (s_axi_awvalid && s_axi_awready) begin
      aw_got_next = 1'b1;
      awaddr_next = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_got_next = 1'b1;
      wdata_next = s_axi_wdata;
    end
    if (bvalid_reg && s_axi_bready) begin
      bvalid_next = 1'b0;
    end
    if (aw_got_reg && w_got_reg && !bvalid_reg) begin
      aw_got_next = 1'b0;
      w_got_next  = 1'b0;
      bvalid_next = 1'b1;
      bresp_next  = iafp_pkg::RESP_OKAY;
      if (awaddr_reg == iafp_pkg::HOST_CMD) begin
        if (!busy) begin
          cmd_next    = wdata_reg[17:0];
          sector_next = wdata_reg[iafp_pkg::CMD_SECTOR_BIT];
          maddr_next  = wdata_reg[iafp_pkg::CMD_ADDR_LSB +: 8];
          mwdata_next = wdata_reg[7:0];
          mrd_next    = wdata_reg[iafp_pkg::CMD_READ_BIT];
          mwr_next    = !wdata_reg[iafp_pkg::CMD_READ_BIT];
        end
      end else if (awaddr_reg != iafp_pkg::HOST_STAT) begin
        bresp_next = iafp_pkg::RESP_DECERR;
      end
    end

    if (rvalid_reg && s_axi_rready) begin
      rvalid_next = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      rvalid_next = 1'b1;
      rresp_next  = iafp_pkg::RESP_OKAY;
      if (s_axi_araddr == iafp_pkg::HOST_CMD) begin
        rdata_next = {14'h0000, cmd_reg};
      end else if (s_axi_araddr == iafp_pkg::HOST_STAT) begin
        rdata_next = 32'h0000_0000;
        rdata_next[iafp_pkg::STAT_BUSY_BIT] = busy;
        rdata_next[7:0] = rcap_reg;
      end else begin
        rdata_next = 32'h0000_0000;
        rresp_next = iafp_pkg::RESP_DECERR;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      aw_got_reg <= 1'b0;
      w_got_reg  <= 1'b0;
      awaddr_reg <= 4'h0;
      wdata_reg  <= 32'h0000_0000;
      bvalid_reg <= 1'b0;
      bresp_reg  <= iafp_pkg::RESP_OKAY;
      rvalid_reg <= 1'b0;
      rresp_reg  <= iafp_pkg::RESP_OKAY;
      rdata_reg  <= 32'h0000_0000;
      cmd_reg    <= 18'h00000;
      sector_reg <= 1'b0;
      maddr_reg  <= 8'h00;
      mwdata_reg <= 8'h00;
      mwr_reg    <= 1'b0;
      mrd_reg    <= 1'b0;
      cap_reg    <= 1'b0;
      rcap_reg   <= 8'h00;
    end else begin
      aw_got_reg <= aw_got_next;
      w_got_reg  <= w_got_next;
      awaddr_reg <= awaddr_next;
      wdata_reg  <= wdata_next;
      bvalid_reg <= bvalid_next;
      bresp_reg  <= bresp_next;
      rvalid_reg <= rvalid_next;
      rresp_reg  <= rresp_next;
      rdata_reg  <= rdata_next;
      cmd_reg    <= cmd_next;
      sector_reg <= sector_next;
      maddr_reg  <= maddr_next;
      mwdata_reg <= mwdata_next;
      mwr_reg    <= mwr_next;
      mrd_reg    <= mrd_next;
      cap_reg    <= cap_next;
      rcap_reg   <= rcap_next;
    end
  end

  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp  = bresp_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rresp  = rresp_reg;
  assign s_axi_rdata  = rdata_reg;
  assign mem.sector   = sector_reg;
  assign mem.addr     = maddr_reg;
  assign mem.wdata    = mwdata_reg;
  assign mem.wr       = mwr_reg;
  assign mem.rd       = mrd_reg;
endmodule
`default_nettype wire

// *** test/iafp_properties.sv ***
// Properties of the memory bus and flash link of the flash programmer
`default_nettype none
module iafp_properties (
  input wire logic       sys_clk,
  input wire logic       rst_n,
  input wire logic       sector,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic       wr,
  input wire logic       rd,
  input wire logic [7:0] rdata,
  input wire logic       flash_req,
  input wire logic [1:0] flash_op,
  input wire logic       flash_ack,
  input wire logic       chip_reset
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  sequence s_key;
    wr && sector && addr == 8'h44 && wdata == 8'h55;
  endsequence
  a_key_resets: assert property
    (s_key |=> chip_reset) else $error("no chip reset");
  a_reset_cause: assert property
    (chip_reset |-> $past(wr && wdata == 8'h55)) else $error("stray reset");
  a_clr_upper_zero: assert property
    (rd && sector && addr == 8'h45 |=> rdata[7:1] == 7'h00)
    else $error("upper bits set");
  a_unmapped_zero: assert property
    (rd && addr < 8'h43 |=> rdata == 8'h00) else $error("unmapped read");
  a_rdata_stands: assert property
    ($changed(rdata) |-> $past(rd)) else $error("read byte moved");
  a_req_holds: assert property
    (flash_req && !flash_ack |=> flash_req && $stable(flash_op))
    else $error("request dropped");
  a_req_drops: assert property
    (flash_req && flash_ack |=> !flash_req) else $error("request held");
  a_op_legal: assert property
    (flash_req |-> flash_op != 2'h3) else $error("reserved op");
endmodule
`default_nettype wire

// *** test/in_application_flash_programmer_tb_top.sv ***
// Bench: AXI4-Lite controller driving the flash programmer
`default_nettype none
`define CHK(nm, e, g) begin n_tests++; if ((e) !== (g)) begin \
  mismatches++; $display("[FAIL] %s exp %h got %h", nm, e, g); end end
module in_application_flash_programmer_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int LDIV = 50;
  logic        sys_clk, rst_n, chip_reset, flash_req, flash_ack, s_axi_wvalid;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic        s_axi_rready;
  logic [1:0]  s_axi_bresp, s_axi_rresp, flash_op;
  logic [3:0]  s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
  logic [31:0] s_axi_wdata, s_axi_rdata, s;
  logic [15:0] flash_addr, flash_wdata, flash_rdata, rd_word, adr, w;
  logic [33:0] exp_q[$], msk_q[$], fl_q[$], e, m, f;
  int          mismatches = 0, n_tests = 0, cyc = 0, n_rst = 0;
  iafp_mem_if  bus ();
  iafp_host iafp_host_i (.sys_clk, .rst_n, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .mem(bus));
  iafp_device #(.SLOW_INTERNAL_OSCILLATOR_DIV(LDIV)) iafp_device_i (.sys_clk, .rst_n, .mem(bus),
    .flash_req, .flash_op, .flash_addr, .flash_wdata, .flash_ack,
    .flash_rdata, .chip_reset);
  iafp_properties iafp_properties_i (.sys_clk, .rst_n, .sector(bus.sector),
    .addr(bus.addr), .wdata(bus.wdata), .wr(bus.wr), .rd(bus.rd),
    .rdata(bus.rdata), .flash_req, .flash_op, .flash_ack, .chip_reset);
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic axi_wr(input logic [31:0] d);
    @(posedge sys_clk);
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(posedge sys_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (!s_axi_bvalid);
    `CHK("bresp", 2'h0, s_axi_bresp)
    s_axi_bready <= 1'h0;
  endtask
  task automatic axi_rd(input logic [3:0] a, input logic [33:0] x, k,
                        output logic [31:0] d);
    exp_q.push_back(x);
    msk_q.push_back(k);
    @(posedge sys_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
      @(posedge sys_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (!s_axi_rvalid);
    d = s_axi_rdata;
    s_axi_rready <= 1'h0;
  endtask
  // Issue one device access and poll until the controller is idle
  task automatic dev(input logic r, c, input logic [7:0] a, d);
    logic [31:0] t;
    axi_wr({14'h0, r, c, a, d});
    do axi_rd(4'h4, '0, '0, t); while (t[8]);
  endtask
  task automatic chk(input logic c, input logic [7:0] a, x, k);
    logic [31:0] t;
    dev(1'h1, c, a, 8'h00);
    axi_rd(4'h4, {26'h0, x}, {2'h3, 23'h0, 1'h1, k}, t);
  endtask
  // Software poll of the main control word until no program, erase or read is pending
  task automatic idle();
    logic [31:0] t;
    do begin
      dev(1'h1, 1'h1, 8'h43, 8'h00);
      axi_rd(4'h4, '0, '0, t);
    end while (t[2] | t[0]);
  endtask
  initial begin
    sys_clk = 1'h0;
    forever #25 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (chip_reset) n_rst++;
    if (cyc == 20000) begin
      mismatches++;
      stop_test();
    end
  end
  always @(posedge sys_clk) begin
    if (s_axi_rvalid && s_axi_rready) begin
      e = exp_q.pop_front();
      m = msk_q.pop_front();
      if (m != 34'h0) `CHK("axi read", e & m, {s_axi_rresp, s_axi_rdata} & m)
    end
  end
  // Flash macro stand-in: answers after a random stall
  initial begin
    {flash_ack, flash_rdata} = '0;
    forever begin
      @(posedge sys_clk);
      if (flash_req) begin
        repeat ($urandom_range(3)) @(posedge sys_clk);
        f = fl_q.size() ? fl_q.pop_front() : '1;
        rd_word = flash_op == 2'h0 ? flash_wdata : 16'h0;
        `CHK("flash op", f, {flash_op, flash_addr, rd_word})
        rd_word = 16'($urandom);
        flash_rdata <= rd_word;
        flash_ack <= 1'h1;
        @(posedge sys_clk);
        flash_ack <= 1'h0;
      end
    end
  end
  initial begin
    {rst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid,
      s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hf;
    void'($urandom(49708));
    repeat (10) @(posedge sys_clk);
    rst_n <= 1'h1;
    chk(1'h1, 8'h43, 8'h00, 8'hff);
    chk(1'h0, 8'h44, 8'h00, 8'hff);
    chk(1'h0, 8'h10, 8'h00, 8'hff);
    axi_rd(4'h8, {2'h3, 32'h0}, '1, s);
    dev(1'h0, 1'h1, 8'h43, 8'h84);
    chk(1'h1, 8'h43, 8'h00, 8'hff);
    dev(1'h0, 1'h1, 8'h45, 8'hff);
    chk(1'h1, 8'h45, 8'h00, 8'hff);
    $display("done: reset and refusals");
    adr = 16'($urandom);
    dev(1'h0, 1'h0, 8'h43, adr[7:0]);
    dev(1'h0, 1'h0, 8'h44, adr[15:8]);
    fl_q.push_back({2'h2, adr, 16'h0});
    dev(1'h0, 1'h1, 8'h43, 8'h33);
    chk(1'h1, 8'h43, 8'h32, 8'hff);
    chk(1'h0, 8'h45, rd_word[7:0], 8'hff);
    chk(1'h0, 8'h46, rd_word[15:8], 8'hff);
    chk(1'h0, 8'h44, adr[15:8], 8'hff);
    dev(1'h0, 1'h1, 8'h43, 8'h31);
    chk(1'h1, 8'h43, 8'h30, 8'hff);
    $display("done: read");
    dev(1'h0, 1'h1, 8'h43, 8'h68);
    chk(1'h1, 8'h43, 8'h08, 8'h88);
    repeat (iafp_pkg::UNLOCK_TICKS * LDIV + 60) @(posedge sys_clk);
    chk(1'h1, 8'h43, 8'h00, 8'h88);
    dev(1'h0, 1'h1, 8'h43, 8'h68);
    for (int i = 0; i < 6; i++)
      dev(1'h0, 1'h0, 8'(8'h47 + i), iafp_pkg::UNLOCK_PAT[i]);
    chk(1'h1, 8'h43, 8'h80, 8'h88);
    $display("done: unlock");
    adr = {8'h00, 8'($urandom) & 8'h7f};
    dev(1'h0, 1'h0, 8'h44, 8'h00);
    dev(1'h0, 1'h0, 8'h43, adr[7:0]);
    for (int i = 0; i < 3; i++) begin
      w = 16'($urandom);
      fl_q.push_back({2'h0, 16'(adr + i), w});
      dev(1'h0, 1'h0, 8'h45, w[7:0]);
      dev(1'h0, 1'h0, 8'h46, w[15:8]);
    end
    dev(1'h0, 1'h1, 8'h43, 8'h84);
    idle();
    chk(1'h0, 8'h43, 8'(adr + 3), 8'hff);
    chk(1'h1, 8'h43, 8'h80, 8'h84);
    fl_q.push_back({2'h1, (adr + 16'h3) & 16'hff80, 16'h0});
    dev(1'h0, 1'h1, 8'h43, 8'h94);
    idle();
    chk(1'h1, 8'h43, 8'h80, 8'h84);
    dev(1'h0, 1'h1, 8'h44, 8'ha5);
    chk(1'h1, 8'h44, 8'ha5, 8'hff);
    dev(1'h0, 1'h1, 8'h44, 8'h55);
    `CHK("chip reset", 1, n_rst)
    dev(1'h0, 1'h1, 8'h43, 8'h00);
    chk(1'h1, 8'h43, 8'h00, 8'hff);
    $display("done: program and lock");
    stop_test();
  end
endmodule
`default_nettype wire
